/* rtl/srb_status_readback_bank.sv */
// Read-only status readback bank with sensor sleep control
`timescale 1ns/1ns
// Functional notes
// - Oscillator two phase word readable, 16 bits
// - Oscillator three phase word readable, 16 bits
// - Each phase byte sampled when read, no latching
// - Sync byte bit 7 holds last hop flag
// - Accum-reset byte bits 3:0 hold last value
// - Temperature code unsigned, Celsius is code minus 80
// - Temperature valid only while sleep is clear
// - Sleep bit stops conversions, resets to zero
module srb_status_readback_bank
	import srb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	input  wire srb_req_t    req,
	input  wire logic [15:0] osc2Phase,
	input  wire logic [15:0] osc3Phase,
	input  wire srb_hop_t    hopTxn,
	input  wire logic [7:0]  tempCode,
	input  wire logic        tempCodeValid,
	output logic [7:0]       rdData_q,
	output logic             rdValid_q,
	output logic             tempSensorSleep_q,
	output logic             tempDataValid_q
);
	logic       hopSyncFlag_q;
	logic [3:0] hopAccumReset_q;
	logic [7:0] dieTemp_q;
	logic [7:0] rdData_d;

	// Snapshot of last fast reconfiguration transaction
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hopSyncFlag_q   <= 1'b0;
			hopAccumReset_q <= 4'h0;
		end else if (clkEn && hopTxn.valid) begin
			hopSyncFlag_q   <= hopTxn.syncFlag;
			hopAccumReset_q <= hopTxn.accumReset;
		end
	end

	// Sleep control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tempSensorSleep_q <= SLEEP_RESET[SLEEP_BIT];
		end else if (clkEn && req.wrEn && req.addr == ADDR_TEMP_SLEEP) begin
			tempSensorSleep_q <= req.wrData[SLEEP_BIT];
		end
	end

	// Temperature capture, frozen while asleep
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dieTemp_q       <= 8'h00;
			tempDataValid_q <= 1'b0;
		end else if (clkEn) begin
			if (tempSensorSleep_q) begin
				tempDataValid_q <= 1'b0;
			end else if (tempCodeValid) begin
				dieTemp_q       <= tempCode;
				tempDataValid_q <= 1'b1;
			end
		end
	end

	// Read decode, live byte sampling
	always_comb begin
		rdData_d = READ_RESET;
		if (req.addr == ADDR_OSC2_PHASE_LO) begin
			rdData_d = osc2Phase[7:0];
		end else if (req.addr == ADDR_OSC2_PHASE_HI) begin
			rdData_d = osc2Phase[15:8];
		end else if (req.addr == ADDR_OSC3_PHASE_LO) begin
			rdData_d = osc3Phase[7:0];
		end else if (req.addr == ADDR_OSC3_PHASE_HI) begin
			rdData_d = osc3Phase[15:8];
		end else if (req.addr == ADDR_HOP_SYNC) begin
			rdData_d = {hopSyncFlag_q, 7'h00};
		end else if (req.addr == ADDR_HOP_ACCUM) begin
			rdData_d = {4'h0, hopAccumReset_q};
		end else if (req.addr == ADDR_DIE_TEMP) begin
			rdData_d = dieTemp_q;
		end else if (req.addr == ADDR_TEMP_SLEEP) begin
			rdData_d = {7'h00, tempSensorSleep_q};
		end
	end

	// Read answer register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_q  <= READ_RESET;
			rdValid_q <= 1'b0;
		end else if (clkEn) begin
			rdValid_q <= req.rdEn;
			if (req.rdEn) begin
				rdData_q <= rdData_d;
			end
		end
	end

	chk_osc2_lo_live: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.rdEn && req.addr == ADDR_OSC2_PHASE_LO
		|=> rdValid_q && rdData_q == $past(osc2Phase[7:0]))
		else $error("osc2 low byte mismatch");

	chk_byte_no_latch: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.rdEn && req.addr == ADDR_OSC2_PHASE_HI
		|=> rdData_q == $past(osc2Phase[15:8]))
		else $error("phase byte not sampled live");

	chk_osc3_lo_live: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.rdEn && req.addr == ADDR_OSC3_PHASE_LO
		|=> rdData_q == $past(osc3Phase[7:0]))
		else $error("osc3 low byte mismatch");

	chk_osc3_hi_live: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.rdEn && req.addr == ADDR_OSC3_PHASE_HI
		|=> rdData_q == $past(osc3Phase[15:8]))
		else $error("osc3 high byte mismatch");

	chk_read_answer: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.rdEn
		|=> rdValid_q)
		else $error("read not answered");

	chk_valid_pulse: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && !req.rdEn
		|=> !rdValid_q)
		else $error("read valid without read");

	chk_data_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!(clkEn && req.rdEn)
		|=> $stable(rdData_q))
		else $error("read data changed without read");

	chk_sync_reserved: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.rdEn && req.addr == ADDR_HOP_SYNC
		|=> rdData_q[6:0] == 7'h00 && rdData_q[HOP_SYNC_BIT] == $past(hopSyncFlag_q))
		else $error("sync snapshot byte wrong");

	chk_sync_snap: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && hopTxn.valid
		|=> hopSyncFlag_q == $past(hopTxn.syncFlag))
		else $error("sync flag snapshot not taken");

	chk_sync_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!(clkEn && hopTxn.valid)
		|=> $stable(hopSyncFlag_q))
		else $error("sync flag snapshot changed");

	chk_accum_snap: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && hopTxn.valid
		|=> hopAccumReset_q == $past(hopTxn.accumReset))
		else $error("accum reset snapshot not taken");

	chk_accum_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!(clkEn && hopTxn.valid)
		|=> $stable(hopAccumReset_q))
		else $error("accum reset snapshot changed");

	chk_accum_read: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.rdEn && req.addr == ADDR_HOP_ACCUM
		|=> rdData_q[ACCUM_MSB:0] == $past(hopAccumReset_q))
		else $error("accum reset read wrong");

	chk_accum_reserved: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.rdEn && req.addr == ADDR_HOP_ACCUM
		|=> rdData_q[7:4] == 4'h0)
		else $error("reserved bits not zero");

	chk_temp_read: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.rdEn && req.addr == ADDR_DIE_TEMP
		|=> rdData_q == $past(dieTemp_q))
		else $error("temperature read wrong");

	chk_temp_capture: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && !tempSensorSleep_q && tempCodeValid
		|=> dieTemp_q == $past(tempCode) && tempDataValid_q)
		else $error("temperature not captured");

	chk_sleep_invalid: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && tempSensorSleep_q
		|=> !tempDataValid_q)
		else $error("temperature valid while asleep");

	chk_sleep_frozen: assert property (
		@(posedge clk) disable iff (!rst_n)
		tempSensorSleep_q && $stable(tempSensorSleep_q)
		|=> $stable(dieTemp_q))
		else $error("conversion ran while asleep");

	chk_sleep_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.wrEn && req.addr == ADDR_TEMP_SLEEP
		|=> tempSensorSleep_q == $past(req.wrData[SLEEP_BIT]))
		else $error("sleep write not taken");

	chk_sleep_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!(clkEn && req.wrEn && req.addr == ADDR_TEMP_SLEEP)
		|=> $stable(tempSensorSleep_q))
		else $error("sleep bit changed without write");

	chk_sleep_read: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.rdEn && req.addr == ADDR_TEMP_SLEEP
		|=> rdData_q == {7'h00, $past(tempSensorSleep_q)})
		else $error("sleep byte read wrong");

	chk_unmapped_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		clkEn && req.rdEn
		&& req.addr != ADDR_OSC2_PHASE_LO && req.addr != ADDR_OSC2_PHASE_HI
		&& req.addr != ADDR_OSC3_PHASE_LO && req.addr != ADDR_OSC3_PHASE_HI
		&& req.addr != ADDR_HOP_SYNC && req.addr != ADDR_HOP_ACCUM
		&& req.addr != ADDR_DIE_TEMP && req.addr != ADDR_TEMP_SLEEP
		|=> rdData_q == READ_RESET)
		else $error("unmapped read not zero");
endmodule

/* rtl/srb_pkg.sv */
// Package for the status readback bank
package srb_pkg;
	localparam logic [15:0] ADDR_OSC2_PHASE_LO = 16'h03A4;
	localparam logic [15:0] ADDR_OSC2_PHASE_HI = 16'h03A5;
	localparam logic [15:0] ADDR_OSC3_PHASE_LO = 16'h03A6;
	localparam logic [15:0] ADDR_OSC3_PHASE_HI = 16'h03A7;
	localparam logic [15:0] ADDR_HOP_SYNC      = 16'h03E0;
	localparam logic [15:0] ADDR_HOP_ACCUM     = 16'h03E1;
	localparam logic [15:0] ADDR_DIE_TEMP      = 16'h0400;
	localparam logic [15:0] ADDR_TEMP_SLEEP    = 16'h0401;
	localparam int          HOP_SYNC_BIT       = 7;
	localparam int          ACCUM_MSB          = 3;
	localparam int          SLEEP_BIT          = 0;
	localparam logic [7:0]  SLEEP_RESET        = 8'h00;
	localparam logic [7:0]  READ_RESET         = 8'h00;
	localparam logic [7:0]  TEMP_OFFSET_C      = 8'h50;

	typedef struct packed {
		logic        rdEn;
		logic        wrEn;
		logic [15:0] addr;
		logic [7:0]  wrData;
	} srb_req_t;

	typedef struct packed {
		logic        valid;
		logic        syncFlag;
		logic [3:0]  accumReset;
	} srb_hop_t;
endpackage

/* verif/srb_host_model.sv */
// Host model issuing byte register accesses
`timescale 1ns/1ns
module srb_host_model
	import srb_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [7:0] rdData_q,
	input  wire logic       rdValid_q,
	output srb_req_t        req
);
	initial req = '0;
	task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic [8:0] q);
		if (a == ADDR_DIE_TEMP) repeat (4) @(negedge clk);
		@(negedge clk);
		req = '{!w, w, a, d};
		@(negedge clk);
		req = '{1'b0, 1'b0, ~a, ~d};
		q = {rdValid_q, rdData_q};
	endtask
endmodule

/* verif/srb_status_readback_bank_tb.sv */
// Testbench for the status readback bank
`timescale 1ns/1ns
module srb_status_readback_bank_tb
	import srb_pkg::*;
;
	logic        clk = 0, rst_n = 0, clkEn = 1, tempCodeValid = 0;
	logic [15:0] osc2Phase = 16'h1234, osc3Phase = 16'hBEEF;
	logic [7:0]  tempCode = 8'h6E, rdData_q;
	logic        rdValid_q, tempSensorSleep_q, tempDataValid_q;
	srb_hop_t    hopTxn = '0;
	srb_req_t    req;
	int          num_errors = 0, check_count = 0, cycles = 0;
	always #4 clk = ~clk;
	srb_status_readback_bank u_srb_status_readback_bank (.clk(clk), .rst_n(rst_n),
		.clkEn(clkEn), .req(req), .osc2Phase(osc2Phase), .osc3Phase(osc3Phase),
		.hopTxn(hopTxn), .tempCode(tempCode), .tempCodeValid(tempCodeValid),
		.rdData_q(rdData_q), .rdValid_q(rdValid_q),
		.tempSensorSleep_q(tempSensorSleep_q), .tempDataValid_q(tempDataValid_q));
	srb_host_model u_srb_host_model (.clk(clk), .rdData_q(rdData_q),
		.rdValid_q(rdValid_q), .req(req));
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
		input logic [8:0] e);
		logic [8:0] q;
		u_srb_host_model.access(w, a, d, q);
		chk(q, e);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00, {1'b1, e});
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] h);
		acc(1'b1, a, d, {1'b0, h});
	endtask
	task automatic pulse(input srb_hop_t h);
		@(negedge clk);
		hopTxn = h;
		tempCodeValid = 1;
		@(negedge clk);
		hopTxn = '0;
		tempCodeValid = 0;
	endtask
	task automatic conclude();
		$display("Checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1;
		chk({8'h00, tempSensorSleep_q}, 9'h000);
		rd(ADDR_OSC2_PHASE_LO, 8'h34);
		osc2Phase = 16'h5678;
		rd(ADDR_OSC2_PHASE_HI, 8'h56);
		rd(ADDR_OSC3_PHASE_LO, 8'hEF);
		rd(ADDR_OSC3_PHASE_HI, 8'hBE);
		pulse('{1'b1, 1'b1, 4'hA}); // Port idle after this
		chk({7'h00, tempSensorSleep_q, tempDataValid_q}, 9'h001);
		rd(ADDR_HOP_SYNC, 8'h80);
		rd(ADDR_HOP_ACCUM, 8'h0A);
		rd(ADDR_DIE_TEMP, 8'h6E);
		clkEn = 0;
		pulse('{1'b1, 1'b0, 4'h5}); // Frozen, port idle after
		acc(1'b0, ADDR_OSC2_PHASE_LO, 8'h00, 9'h16E);
		acc(1'b1, ADDR_TEMP_SLEEP, 8'h01, 9'h16E);
		clkEn = 1;
		chk({8'h00, tempSensorSleep_q}, 9'h000);
		rd(ADDR_HOP_SYNC, 8'h80);
		rd(ADDR_HOP_ACCUM, 8'h0A);
		wr(ADDR_TEMP_SLEEP, 8'hFF, 8'h0A);
		rd(ADDR_TEMP_SLEEP, 8'h01);
		chk({7'h00, tempSensorSleep_q, tempDataValid_q}, 9'h002);
		tempCode = 8'h22;
		pulse('0);
		rd(ADDR_DIE_TEMP, 8'h6E);
		wr(ADDR_OSC2_PHASE_LO, 8'h00, 8'h6E);
		rd(ADDR_OSC2_PHASE_LO, 8'h78);
		rd(16'h0300, 8'h00);
		wr(ADDR_TEMP_SLEEP, 8'h00, 8'h00);
		pulse('0);
		chk({7'h00, tempSensorSleep_q, tempDataValid_q}, 9'h001);
		rd(ADDR_DIE_TEMP, 8'h22);
		wr(ADDR_TEMP_SLEEP, 8'h01, 8'h22);
		rst_n = 0;
		repeat (2) @(negedge clk);
		rst_n = 1;
		chk({7'h00, tempSensorSleep_q, tempDataValid_q}, 9'h000);
		rd(ADDR_HOP_SYNC, 8'h00);
		rd(ADDR_DIE_TEMP, 8'h00);
		conclude();
	end
endmodule
